/* flag_pin_cfg.svh */
`ifndef FLAG_PIN_CFG_SVH
`define FLAG_PIN_CFG_SVH

// Register offsets on the control port.
`define REG_STICKY_FLAGS   7'h60
`define REG_LIVE_STATUS    7'h61
`define REG_PIN_CONTROL    7'h62
`define REG_BUTTON_CLEAR   7'h0E

// Pin control field positions.
`define PIN_FUNC_HI        7
`define PIN_FUNC_LO        4
`define PIN_CLK_SEL_BIT    3
`define PIN_IRQ_FORM_BIT   2
`define PIN_IN_BIT         1
`define PIN_OUT_BIT        0
`define PIN_CTRL_RESET     8'h00
`define PIN_WRITE_MASK     8'hFD

// Live status field positions.
`define STAT_SHORT_HI      7
`define STAT_SHORT_LO      4
`define STAT_BUTTON_BIT    3
`define STAT_HEADSET_BIT   2
`define STAT_GATE_HI       1
`define STAT_GATE_LO       0

// Clock rate and interrupt pulse timing.
`define CLK_FREQ_KHZ       50000
`define IRQ_PULSE_US       2000
`define IRQ_GAP_US         2000
`define IRQ_PULSE_CYC      ((`IRQ_PULSE_US * `CLK_FREQ_KHZ) / 1000)
`define IRQ_GAP_CYC        ((`IRQ_GAP_US * `CLK_FREQ_KHZ) / 1000)

`endif

/* flag_pin_pkg.sv */
package flag_pin_pkg;

    // Function codes of the multi-function pin.
    typedef enum logic [3:0] {
        FN_OFF      = 4'h0,
        FN_REC_WCLK = 4'h1,
        FN_DIV1     = 4'h2,
        FN_DIV2     = 4'h3,
        FN_DIV4     = 4'h4,
        FN_DIV8     = 4'h5,
        FN_IRQ_SC   = 4'h6,
        FN_IRQ_GATE = 4'h7,
        FN_GP_IN    = 4'h8,
        FN_GP_OUT   = 4'h9,
        FN_MIC_CLK  = 4'hA,
        FN_WCLK     = 4'hB,
        FN_IRQ_BTN  = 4'hC,
        FN_IRQ_HS   = 4'hD,
        FN_IRQ_HSB  = 4'hE,
        FN_IRQ_ALL  = 4'hF
    } pin_func_type;

    // Interrupt pulse generator states.
    typedef enum logic [1:0] {
        PL_IDLE,
        PL_HIGH,
        PL_GAP
    } pulse_state_type;

endpackage

/* irq_pulse_gen.sv */
`include "flag_pin_cfg.svh"

// Shapes a combined event level into a single pulse or a repeating train.
module irq_pulse_gen #(
    parameter int PULSE_CYC = `IRQ_PULSE_CYC,  // High time of one pulse.
    parameter int GAP_CYC   = `IRQ_GAP_CYC     // Low time between repeats.
) (
    input  wire logic clk,          // System clock.
    input  wire logic rst_b,        // Asynchronous reset, active low.
    input  wire logic event_lvl,    // Combined event condition.
    input  wire logic repeat_mode,  // One selects repeated pulses.
    input  wire logic flags_read,   // Host read of the sticky flags.
    output logic      irq_out       // Shaped interrupt, active high.
);

    typedef struct packed {
        flag_pin_pkg::pulse_state_type st;
        logic [31:0]                   cnt;
        logic                          prev;
        logic                          irq;
        logic                          stop;
    } gen_type;

    gen_type cur_q;
    gen_type nxt_d;

    // =========================================================
    // Pulse sequencing
    // A rising edge starts a pulse; in repeat mode the train runs until the
    // sticky flags are read, so a missed read keeps nagging the host.
    always_comb begin
        nxt_d      = cur_q;
        nxt_d.prev = event_lvl;
        case (cur_q.st)
            flag_pin_pkg::PL_IDLE: begin
                // RQ18: rising edge start
                if (event_lvl && !cur_q.prev) begin
                    nxt_d.st  = flag_pin_pkg::PL_HIGH;
                    nxt_d.cnt  = 32'(PULSE_CYC - 1);
                    nxt_d.irq  = 1'b1;
                    nxt_d.stop = 1'b0;
                end
            end
            flag_pin_pkg::PL_HIGH: begin
                // A read strobe lasts one cycle, so a read during the pulse is remembered.
                if (flags_read) begin
                    nxt_d.stop = 1'b1;
                end
                if (cur_q.cnt != 32'h0) begin
                    nxt_d.cnt = cur_q.cnt - 32'h1;
                end else begin
                    nxt_d.irq = 1'b0;
                    // RQ14: repeat until read
                    if (repeat_mode && !flags_read && !cur_q.stop) begin
                        nxt_d.st  = flag_pin_pkg::PL_GAP;
                        nxt_d.cnt = 32'(GAP_CYC - 1);
                    end else begin
                        nxt_d.st = flag_pin_pkg::PL_IDLE;
                    end
                end
            end
            flag_pin_pkg::PL_GAP: begin
                if (flags_read || !repeat_mode) begin
                    nxt_d.st = flag_pin_pkg::PL_IDLE;
                end else if (cur_q.cnt != 32'h0) begin
                    nxt_d.cnt = cur_q.cnt - 32'h1;
                end else begin
                    nxt_d.st  = flag_pin_pkg::PL_HIGH;
                    nxt_d.cnt = 32'(PULSE_CYC - 1);
                    nxt_d.irq = 1'b1;
                end
            end
            default: begin
                nxt_d.st  = flag_pin_pkg::PL_IDLE;
                nxt_d.irq = 1'b0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_q <= '{st: flag_pin_pkg::PL_IDLE, cnt: 32'h0, prev: 1'b0, irq: 1'b0, stop: 1'b0};
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign irq_out = cur_q.irq;

endmodule

/* status_flags_and_pin_mux.sv */
`include "flag_pin_cfg.svh"

// Contract
// RQ1: Status bits 7..4 show live short circuit on the four headphone drivers.
// RQ2: Status bit 3 latches a button press; cleared only by reading register 14.
// RQ3: Status bit 2 shows headset currently present.
// RQ4: Status bits 1,0 show left/right record power below noise-gate threshold.
// RQ5: Pin function resets to disabled; 0001 gives record word clock.
// RQ6: Functions 0010..0101 output selected clock divided by 1, 2, 4, 8.
// RQ7: 0110 outputs short-circuit interrupt, 0111 noise-gate interrupt.
// RQ8: 1000 makes the pin an input, 1001 an output.
// RQ9: 1010 outputs the digital microphone modulator clock.
// RQ10: 1011 carries the serial-bus word clock, in or out per direction input.
// RQ11: 1100 outputs active-high button interrupt following the debounced press.
// RQ12: 1101..1111 output headset, headset|button, or all-event interrupts.
// RQ13: Control bit 3 picks loop clock (0) or divider mux clock (1).
// RQ14: Control bit 2 picks single 2 ms pulse or repeats until flags read.
// RQ15: Control bit 1 reads back the synchronised pin level.
// RQ16: Output mode drives control bit 0 onto the pin.
// RQ17: Sticky flags register holds event bits until the host reads it.
// RQ18: Interrupt pulses are timed by a counter started on a rising event.
// RQ19: Read-only bits ignore writes; unused codes keep the pin disabled.
module status_flags_and_pin_mux #(
    parameter int PULSE_CYC = `IRQ_PULSE_CYC,  // Interrupt pulse length in clocks.
    parameter int GAP_CYC   = `IRQ_GAP_CYC     // Gap between repeated pulses.
) (
    input  wire logic       clk,             // System clock, 50 MHz.
    input  wire logic       rst_b,           // Asynchronous reset, active low.
    input  wire logic [6:0] reg_addr,        // Register address.
    input  wire logic       reg_wr,          // Write strobe, one cycle.
    input  wire logic       reg_rd,          // Read strobe, one cycle.
    input  wire logic [7:0] reg_wdata,       // Write data.
    output logic      [7:0] reg_rdata,       // Read data, registered.
    input  wire logic [3:0] short_det,       // Short detect per driver, bit 3 = left main.
    input  wire logic       button_det,      // Debounced button pressed level.
    input  wire logic       headset_det,     // Headset present level.
    input  wire logic [1:0] gate_det,        // Noise gate, bit 1 left, bit 0 right.
    input  wire logic       pll_clk_in,      // Loop clock source.
    input  wire logic       divmux_clk_in,   // Divider mux clock source.
    input  wire logic       rec_wclk_in,     // Record-side word clock.
    input  wire logic       mic_clk_in,      // Microphone modulator clock.
    input  wire logic       wclk_out_val,    // Word clock when this end is master.
    input  wire logic       wclk_is_out,     // Word clock direction, one = output.
    output logic            wclk_in_val,     // Word clock seen on the pin.
    input  wire logic       pin_i,           // Pin level from the pad.
    output logic            pin_o,           // Pin output value.
    output logic            pin_oe_b         // Pin enable, low while driving.
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sticky;
        logic       button;
        logic [3:0] short_s;
        logic       headset_s;
        logic [1:0] gate_s;
        logic [2:0] pin_sync;
        logic       pin_lvl;
        logic [2:0] clk_sync;
        logic [2:0] div_cnt;
        logic [7:0] rdata;
    } state_type;

    state_type st_q;
    state_type st_d;

    logic [7:0]                 live_stat;
    logic                       rd_sticky;
    logic                       rd_button;
    logic                       sel_clk;
    logic                       div_clk;
    logic                       ev_short;
    logic                       ev_gate;
    logic                       ev_sel;
    logic                       irq_shaped;
    logic                       src_clk;
    flag_pin_pkg::pin_func_type func;

    assign func      = flag_pin_pkg::pin_func_type'(st_q.ctrl[`PIN_FUNC_HI:`PIN_FUNC_LO]);
    assign rd_sticky = reg_rd && (reg_addr == `REG_STICKY_FLAGS);
    assign rd_button = reg_rd && (reg_addr == `REG_BUTTON_CLEAR);

    // =========================================================
    // Live status assembly
    always_comb begin
        live_stat = 8'h00;
        // RQ1: live short status
        live_stat[`STAT_SHORT_HI:`STAT_SHORT_LO] = st_q.short_s;
        // RQ2: latched button bit
        live_stat[`STAT_BUTTON_BIT] = st_q.button;
        // RQ3: headset present bit
        live_stat[`STAT_HEADSET_BIT] = st_q.headset_s;
        // RQ4: noise gate bits
        live_stat[`STAT_GATE_HI:`STAT_GATE_LO] = st_q.gate_s;
    end

    // Event groups feeding the interrupt functions.
    assign ev_short = |st_q.short_s;
    assign ev_gate  = |st_q.gate_s;

    // =========================================================
    // Clock source selection
    // The clock sources are sampled, so the divided outputs are only clean
    // for sources well below half the system clock rate.
    // RQ13: divider source select
    assign src_clk = st_q.ctrl[`PIN_CLK_SEL_BIT] ? divmux_clk_in : pll_clk_in;

    // RQ6: divide by 1, 2, 4, 8
    always_comb begin
        case (func)
            flag_pin_pkg::FN_DIV1: sel_clk = st_q.clk_sync[1];
            flag_pin_pkg::FN_DIV2: sel_clk = st_q.div_cnt[0];
            flag_pin_pkg::FN_DIV4: sel_clk = st_q.div_cnt[1];
            flag_pin_pkg::FN_DIV8: sel_clk = st_q.div_cnt[2];
            default:               sel_clk = 1'b0;
        endcase
    end
    assign div_clk = sel_clk;

    // =========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        // Detector inputs arrive from analog circuits, so they are registered.
        st_d.short_s   = short_det;
        st_d.headset_s = headset_det;
        st_d.gate_s    = gate_det;
        // RQ15: three-stage pin sync
        st_d.pin_sync = {st_q.pin_sync[1:0], pin_i};
        if (st_q.pin_sync[2] == st_q.pin_sync[1]) begin
            st_d.pin_lvl = st_q.pin_sync[1];
        end
        st_d.clk_sync = {st_q.clk_sync[1:0], src_clk};
        // Count rising edges of the synchronised source clock.
        if (st_q.clk_sync[1] && !st_q.clk_sync[2]) begin
            st_d.div_cnt = st_q.div_cnt + 3'h1;
        end
        // RQ2: clear on read, set wins
        if (rd_button) begin
            st_d.button = 1'b0;
        end
        if (button_det) begin
            st_d.button = 1'b1;
        end
        // RQ17: sticky clear on read
        if (rd_sticky) begin
            st_d.sticky = 8'h00;
        end
        st_d.sticky = st_d.sticky | live_stat;
        // RQ19: read-only bits masked
        if (reg_wr && (reg_addr == `REG_PIN_CONTROL)) begin
            st_d.ctrl = reg_wdata & `PIN_WRITE_MASK;
        end
        st_d.ctrl[`PIN_IN_BIT] = st_d.pin_lvl;
        // Register read data.
        if (reg_rd) begin
            case (reg_addr)
                `REG_STICKY_FLAGS: st_d.rdata = st_q.sticky;
                `REG_LIVE_STATUS:  st_d.rdata = live_stat;
                `REG_PIN_CONTROL:  st_d.rdata = st_q.ctrl;
                default:           st_d.rdata = 8'h00;
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // Interrupt source selection
    always_comb begin
        case (func)
            // RQ7: short and gate interrupts
            flag_pin_pkg::FN_IRQ_SC:   ev_sel = ev_short;
            flag_pin_pkg::FN_IRQ_GATE: ev_sel = ev_gate;
            // RQ12: combined interrupt sources
            flag_pin_pkg::FN_IRQ_HS:   ev_sel = st_q.headset_s;
            flag_pin_pkg::FN_IRQ_HSB:  ev_sel = st_q.headset_s | st_q.button;
            flag_pin_pkg::FN_IRQ_ALL:  ev_sel = st_q.headset_s | st_q.button | ev_short | ev_gate;
            default:                   ev_sel = 1'b0;
        endcase
    end

    irq_pulse_gen #(
        .PULSE_CYC (PULSE_CYC),
        .GAP_CYC   (GAP_CYC)
    ) u_pulse (
        .clk         (clk),
        .rst_b       (rst_b),
        .event_lvl   (ev_sel),
        .repeat_mode (st_q.ctrl[`PIN_IRQ_FORM_BIT]),
        .flags_read  (rd_sticky),
        .irq_out     (irq_shaped)
    );

    // =========================================================
    // Pin multiplexer
    always_comb begin
        pin_o    = 1'b0;
        pin_oe_b = 1'b1;
        case (func)
            // RQ5: record word clock
            flag_pin_pkg::FN_REC_WCLK: begin
                pin_o    = rec_wclk_in;
                pin_oe_b = 1'b0;
            end
            flag_pin_pkg::FN_DIV1, flag_pin_pkg::FN_DIV2,
            flag_pin_pkg::FN_DIV4, flag_pin_pkg::FN_DIV8: begin
                pin_o    = div_clk;
                pin_oe_b = 1'b0;
            end
            flag_pin_pkg::FN_IRQ_SC, flag_pin_pkg::FN_IRQ_GATE, flag_pin_pkg::FN_IRQ_HS,
            flag_pin_pkg::FN_IRQ_HSB, flag_pin_pkg::FN_IRQ_ALL: begin
                pin_o    = irq_shaped;
                pin_oe_b = 1'b0;
            end
            // RQ16: output value bit
            flag_pin_pkg::FN_GP_OUT: begin
                pin_o    = st_q.ctrl[`PIN_OUT_BIT];
                pin_oe_b = 1'b0;
            end
            // RQ9: microphone clock
            flag_pin_pkg::FN_MIC_CLK: begin
                pin_o    = mic_clk_in;
                pin_oe_b = 1'b0;
            end
            // RQ10: word clock direction
            flag_pin_pkg::FN_WCLK: begin
                pin_o    = wclk_out_val;
                pin_oe_b = !wclk_is_out;
            end
            // RQ11: button level interrupt
            flag_pin_pkg::FN_IRQ_BTN: begin
                pin_o    = button_det;
                pin_oe_b = 1'b0;
            end
            // RQ8: input mode releases pin
            default: begin
                pin_o    = 1'b0;
                pin_oe_b = 1'b1;
            end
        endcase
    end

    // Word clock seen on the pin when this end listens.
    assign wclk_in_val = (func == flag_pin_pkg::FN_WCLK) && !wclk_is_out && st_q.pin_lvl;
    assign reg_rdata   = st_q.rdata;

endmodule

/* status_flags_and_pin_mux_asserts.sv */
// ====================================
// Port checker for the flag and pin block.
module status_flags_and_pin_mux_asserts #(
    parameter int PULSE_CYC = 10,  // Interrupt pulse length.
    parameter int GAP_CYC   = 10   // Repeat gap, passed on by the bind.
) (
    input wire logic       clk,           // Clock.
    input wire logic       rst_b,         // Reset, active low.
    input wire logic [6:0] reg_addr,      // Address.
    input wire logic       reg_wr,        // Write strobe.
    input wire logic       reg_rd,        // Read strobe.
    input wire logic [7:0] reg_wdata,     // Write data.
    input wire logic [7:0] reg_rdata,     // Read data.
    input wire logic [3:0] short_det,     // Short detect.
    input wire logic       headset_det,   // Headset level.
    input wire logic [1:0] gate_det,      // Noise gate.
    input wire logic       button_det,    // Button level.
    input wire logic       rec_wclk_in,   // Record word clock.
    input wire logic       mic_clk_in,    // Microphone clock.
    input wire logic       wclk_out_val,  // Word clock to drive.
    input wire logic       wclk_is_out,   // Word clock direction.
    input wire logic       pin_o,         // Pin value.
    input wire logic       pin_oe_b       // Pin enable, low drives.
);
    typedef struct packed {
        logic [7:0]  ctl;  // Shadow of the pin control register.
        logic [15:0] hi;   // Cycles the pin has stood high.
    } shadow_type;
    shadow_type s_q;
    shadow_type s_d;
    logic [3:0] fn;
    logic       irq;
    // Mirror control writes, which land on the same edge as in the block.
    always_comb begin
        s_d = s_q;
        if (reg_wr && reg_addr == 7'h62) begin
            s_d.ctl = reg_wdata;
        end
        s_d.hi = pin_o ? s_q.hi + 16'h1 : 16'h0;
        fn = s_q.ctl[7:4];
        irq = fn inside {4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
    end
    // Shadow state register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_off_tristate: assert property ((fn == 4'h0 || fn == 4'h8) |-> pin_oe_b)
        else $error("pin driven while disabled or input");
    chk_gpout_level: assert property (fn == 4'h9 |-> !pin_oe_b && pin_o == s_q.ctl[0])
        else $error("output mode level wrong");
    chk_rec_wclk: assert property (fn == 4'h1 |-> !pin_oe_b && pin_o == rec_wclk_in)
        else $error("record word clock missing");
    chk_mic_clk: assert property (fn == 4'hA |-> !pin_oe_b && pin_o == mic_clk_in)
        else $error("microphone clock missing");
    chk_wclk_dir: assert property (fn == 4'hB |-> pin_oe_b == !wclk_is_out && (!wclk_is_out || pin_o == wclk_out_val))
        else $error("word clock direction wrong");
    chk_btn_level: assert property (fn == 4'hC |-> !pin_oe_b && pin_o == button_det)
        else $error("button interrupt wrong");
    chk_live_read: assert property (reg_rd && reg_addr == 7'h61 |=> (reg_rdata & 8'hF7) ==
        {$past(short_det, 2), 1'b0, $past(headset_det, 2), $past(gate_det, 2)})
        else $error("live status read wrong");
    chk_ctrl_read: assert property (reg_rd && reg_addr == 7'h62 |=> (reg_rdata & 8'hFD) == ($past(s_q.ctl) & 8'hFD))
        else $error("control read back wrong");
    chk_pulse_len: assert property ($fell(pin_o) && irq && $stable(s_q.ctl) |-> s_q.hi == 16'(PULSE_CYC))
        else $error("interrupt pulse length wrong");
    chk_repeat_gap: assert property ($fell(pin_o) && irq && s_q.ctl[2] && $stable(s_q.ctl) |=> !pin_o [*8])
        else $error("repeat gap too short");
endmodule

bind status_flags_and_pin_mux status_flags_and_pin_mux_asserts #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) u_chk (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .short_det(short_det), .headset_det(headset_det), .gate_det(gate_det),
    .button_det(button_det), .rec_wclk_in(rec_wclk_in), .mic_clk_in(mic_clk_in), .wclk_out_val(wclk_out_val),
    .wclk_is_out(wclk_is_out), .pin_o(pin_o), .pin_oe_b(pin_oe_b));

/* pin_partner.sv */
// ====================================
// External logic on the multi-function pin.
module pin_partner (
    input  wire logic clk,       // Clock.
    input  wire logic pin_o,     // Block output value.
    input  wire logic pin_oe_b,  // Block enable, low drives.
    input  wire logic ext_en,    // External logic drives.
    input  wire logic ext_val,   // External level.
    output logic      pin_i      // Resolved pin level.
);
    logic last_q = 1'b0;
    // A floating line shows the inverse of its last level, so a stale value never passes.
    always_comb begin
        pin_i = !pin_oe_b ? pin_o : (ext_en ? ext_val : !last_q);
    end
    // Remember the level for the float case.
    always_ff @(posedge clk) begin
        last_q <= pin_i;
    end
endmodule

/* tb_status_flags_and_pin_mux.sv */
// ====================================
// Self-checking bench for the flag and pin block.
module tb_status_flags_and_pin_mux;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 10;
    localparam logic [3:0] pass_fn [4] = '{4'h1, 4'hA, 4'hB, 4'hC};
    localparam logic [3:0] irq_fn [6] = '{4'h6, 4'h7, 4'hD, 4'hE, 4'hF, 4'hF};
    localparam logic [7:0] ev_bit [6] = '{8'h80, 8'h01, 8'h04, 8'h08, 8'h02, 8'h40};
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v, d;
    logic [3:0] short_det = 4'h0, r;
    logic [1:0] gate_det = 2'h0;
    logic button_det = 1'b0, headset_det = 1'b0, rec_wclk_in = 1'b0, mic_clk_in = 1'b0;
    logic wclk_out_val = 1'b0, wclk_is_out = 1'b0, ext_en = 1'b0, ext_val = 1'b0;
    logic wclk_in_val, pin_i, pin_o, pin_oe_b;
    int cyc = 0, seed = 99, bad_count = 0, n_tests = 0, i, c;
    wire logic pll_clk_in = cyc[3];
    wire logic divmux_clk_in = cyc[2];

    status_flags_and_pin_mux #(.PULSE_CYC(PC), .GAP_CYC(PC)) uut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .short_det(short_det), .button_det(button_det),
        .headset_det(headset_det), .gate_det(gate_det), .pll_clk_in(pll_clk_in), .divmux_clk_in(divmux_clk_in),
        .rec_wclk_in(rec_wclk_in), .mic_clk_in(mic_clk_in), .wclk_out_val(wclk_out_val),
        .wclk_is_out(wclk_is_out), .wclk_in_val(wclk_in_val), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_b(pin_oe_b));
    pin_partner far_end (.clk(clk), .pin_o(pin_o), .pin_oe_b(pin_oe_b), .ext_en(ext_en), .ext_val(ext_val),
        .pin_i(pin_i));

    // Clock.
    always #10 clk = ~clk;
    // Cycle count feeds the slow clock sources and cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 x = reg_rdata;
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] x;
        rd(a, x);
        check(x & m, e);
    endtask
    // Detector levels laid out as the live status byte.
    task automatic set_ev(input logic [7:0] m);
        @(posedge clk);
        short_det <= m[7:4];
        button_det <= m[3];
        headset_det <= m[2];
        gate_det <= m[1:0];
    endtask
    task automatic count_rises(input int n, output int k);
        logic last;
        last = pin_o;
        k = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (pin_o && !last) k++;
            last = pin_o;
        end
    endtask
    // Waits a bounded time for a pulse, then counts its high cycles.
    task automatic pulse_len(output int k);
        int w;
        w = 0;
        k = 0;
        while (!pin_o && w < 40) begin
            @(posedge clk);
            #1;
            w++;
        end
        while (pin_o && k < 200) begin
            k++;
            @(posedge clk);
            #1;
        end
    endtask
    // Source rises in 256 cycles are 16 for the loop clock and 32 for the mux clock.
    function automatic int exp_rises(input int k);
        return k == 4 ? 32 : 16 >> k;
    endfunction

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(7'h61, 8'hFF, 8'h00);
        rdchk(7'h62, 8'hFF, 8'h00);
        rdchk(7'h33, 8'hFF, 8'h00);
        check(8'(pin_oe_b), 8'h1);
        for (i = 0; i < 20; i++) begin
            d = 8'($random(seed)) & 8'hF7;
            set_ev(d);
            wr(7'h61, 8'hFF);
            rdchk(7'h61, 8'hF7, d);
        end
        set_ev(8'h08);
        set_ev(8'h00);
        repeat (3) @(posedge clk);
        rdchk(7'h61, 8'h08, 8'h08);
        rdchk(7'h61, 8'h08, 8'h08);
        rd(7'h0E, v);
        rdchk(7'h61, 8'h08, 8'h00);
        for (i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            wr(7'h62, d);
            rdchk(7'h62, 8'hFD, d & 8'hFD);
        end
        @(posedge clk);
        ext_en <= 1'b1;
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            ext_val <= i[0];
            wr(7'h62, 8'h80);
            repeat (6) @(posedge clk);
            rdchk(7'h62, 8'h02, {6'h00, i[0], 1'b0});
            wr(7'h62, 8'hB0);
            repeat (6) @(posedge clk);
            check({7'h00, wclk_in_val}, {7'h00, i[0]});
        end
        @(posedge clk);
        ext_en <= 1'b0;
        wclk_is_out <= 1'b1;
        for (i = 0; i < 2; i++) begin
            wr(7'h62, {7'h48, i[0]});
            check({6'h00, pin_oe_b, pin_o}, {7'h00, i[0]});
            repeat (6) @(posedge clk);
            rdchk(7'h62, 8'h02, {6'h00, i[0], 1'b0});
        end
        for (i = 0; i < 16; i++) begin
            r = 4'($random(seed));
            @(posedge clk);
            rec_wclk_in <= r[0];
            mic_clk_in <= r[1];
            wclk_out_val <= r[2];
            button_det <= r[3];
            wr(7'h62, {pass_fn[i % 4], 4'h0});
            check({6'h00, pin_oe_b, pin_o}, {7'h00, r[i % 4]});
        end
        for (i = 0; i < 5; i++) begin
            wr(7'h62, {4'(2 + i % 4), i == 4, 3'h0});
            count_rises(256, c);
            check(8'(c >= exp_rises(i) - 1 && c <= exp_rises(i) + 1), 8'h1);
        end
        set_ev(8'h00);
        repeat (30) @(posedge clk);
        rd(7'h0E, v);
        rd(7'h60, v);
        for (i = 0; i < 6; i++) begin
            wr(7'h62, {irq_fn[i], 1'b0, i == 5, 2'h0});
            set_ev(ev_bit[i]);
            pulse_len(c);
            check(8'(c), 8'(PC));
            set_ev(8'h00);
            if (i == 5) begin
                count_rises(40, c);
                check(8'(c > 0), 8'h1);
            end
            rd(7'h0E, v);
            rdchk(7'h60, ev_bit[i], ev_bit[i]);
            rdchk(7'h60, ev_bit[i], 8'h00);
            repeat (20) @(posedge clk);
            count_rises(60, c);
            check(8'(c), 8'h00);
        end
        tally_and_finish();
    end
endmodule
